// File: common/telemetry_cfg_pkg.sv
// Constants for the telemetry and configuration register set.
// Assumes one clock domain and an ADC macro that hands over 8-bit samples on that clock.
package telemetry_cfg_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Command codes
    localparam logic [7:0] CODE_RUN_CONTROL   = 8'h01;
    localparam logic [7:0] CODE_TURN_ON_SRC   = 8'h02;
    localparam logic [7:0] CODE_WRITE_LOCK    = 8'h10;
    localparam logic [7:0] CODE_STORE_ALL     = 8'h15;
    localparam logic [7:0] CODE_RESTORE_ALL   = 8'h16;
    localparam logic [7:0] CODE_VOUT_EXPONENT = 8'h20;
    localparam logic [7:0] CODE_SENSE_RATIO   = 8'h2A;
    localparam logic [7:0] CODE_OC_THRESH     = 8'h46;
    localparam logic [7:0] CODE_OT_FAULT      = 8'h4F;
    localparam logic [7:0] CODE_OT_WARN       = 8'h51;
    localparam logic [7:0] CODE_VOUT_READING  = 8'h8B;
    localparam logic [7:0] CODE_IOUT_READING  = 8'h8C;
    localparam logic [7:0] CODE_TEMP_READING  = 8'h8D;
    localparam logic [7:0] CODE_RAMP_TIME     = 8'hD1;
    localparam logic [7:0] CODE_SW_DIVISOR    = 8'hD2;
    localparam logic [7:0] CODE_TRIM_UP       = 8'hD4;
    localparam logic [7:0] CODE_TRIM_DOWN     = 8'hD5;
    localparam logic [7:0] CODE_REF_SKIP_OPTS = 8'hDA;

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration table, index order fixed
    localparam int CFG_N = 12;
    localparam logic [3:0] IDX_RUN     = 4'h0;
    localparam logic [3:0] IDX_ONOFF   = 4'h1;
    localparam logic [3:0] IDX_LOCK    = 4'h2;
    localparam logic [3:0] IDX_RATIO   = 4'h3;
    localparam logic [3:0] IDX_TRIM_UP = 4'h9;
    localparam logic [3:0] IDX_TRIM_DN = 4'hA;
    localparam logic [3:0] IDX_NONE    = 4'hF;

    localparam logic [7:0] CFG_CODE [CFG_N] = '{
        CODE_RUN_CONTROL, CODE_TURN_ON_SRC, CODE_WRITE_LOCK, CODE_SENSE_RATIO,
        CODE_OC_THRESH, CODE_OT_FAULT, CODE_OT_WARN, CODE_RAMP_TIME,
        CODE_SW_DIVISOR, CODE_TRIM_UP, CODE_TRIM_DOWN, CODE_REF_SKIP_OPTS};

    // Factory defaults
    localparam logic [15:0] CFG_DEFAULT [CFG_N] = '{
        16'h0080, 16'h0014, 16'h0000, 16'hE801,
        16'h0815, 16'h101D, 16'h101A, 16'h000E,
        16'h000C, 16'h0000, 16'h0000, 16'h0005};

    // Bit i set: entry i is a byte register
    localparam logic [CFG_N-1:0] CFG_IS_BYTE = 12'h987;

    ////////////////////////////////////////////////////////////////////////////////
    // Field layout and values
    localparam int RUN_ON_BIT      = 7;
    localparam int RUN_MARGIN_HI   = 5;
    localparam int RUN_MARGIN_LO   = 4;
    localparam logic [1:0] MARGIN_HIGH = 2'h2;
    localparam logic [1:0] MARGIN_LOW  = 2'h1;
    localparam logic [15:0] TRIM_MAX   = 16'h0007;
    localparam logic [7:0] LOCK_ALL    = 8'h80;
    localparam logic [7:0] LOCK_BUT_RUN   = 8'h40;
    localparam logic [7:0] LOCK_BUT_ONOFF = 8'h20;
    localparam logic [4:0] IOUT_EXPONENT = 5'h1F;
    localparam logic [4:0] TEMP_EXPONENT = 5'h00;
    localparam logic [7:0] VOUT_MODE_BASE = 8'h18;
    localparam logic [4:0] RATIO_MAX_SHIFT = 5'h03;
    localparam logic [1:0] CH_CURRENT = 2'h0;
    localparam logic [1:0] CH_TEMP    = 2'h1;
    localparam logic [1:0] CH_VOLTAGE = 2'h2;

endpackage : telemetry_cfg_pkg

// File: hw/telemetry_cfg_regs.sv
// Telemetry and configuration register set of a single-phase step-down controller.
// Assumes a command layer on clk that presents decoded command codes, and an ADC on clk.
//
// Contract
// - One 8-bit ADC feeds all current, temperature and voltage telemetry.
// - Current comes from monitor-minus-reference at 5 mV/A; zero difference is 0 A.
// - Current word: 5-bit exponent in bits 15..11, 11-bit mantissa in 10..0.
// - Current exponent always minus one, so one mantissa step is half an ampere.
// - Voltage mode register reports the 5-bit exponent in bits 4..0.
// - Voltage reading is a 16-bit mantissa; host scales it by the mode exponent.
// - Mode follows sense ratio: 1, 1/2, 1/4, 1/8 give 0x18..0x1B.
// - Temperature word like current word, exponent zero, one step per degree.
// - Temperature converted at 8 mV per degree, 0.6 V meaning zero degrees.
// - Overcurrent limit mantissa in 10..0, exponent plus one, two amperes per step.
// - Overheat limit mantissa with exponent plus two, four degrees per step.
// - Overheat defaults conflict; table values 116 and 104 degrees are used.
// - At power-up the stored configuration loads before the settings take effect.
// - Store-all copies configuration to the store; restore reloads it from there.
// - Write lock blocks configuration writes; default 0x00 leaves writes enabled.
// - Run control defaults to 0x80: output on, nominal voltage, no margin.
// - Turn-on source config defaults to 0x14: enable pin alone switches output; here it is only stored, output_on follows run control bit 7.
// - Reference and skip options default to 0x05.
// - Current reading at code 8Ch, temperature reading at code 8Dh.
// - Margin-high setting N in 0..7 raises the target by N half-percent steps.
`timescale 1ns/100ps
`default_nettype none

module telemetry_cfg_regs
    import telemetry_cfg_pkg::*;
#(
    parameter int          ADC_BITS       = 8,
    parameter logic [7:0]  TEMP_ZERO_CODE = 8'h4B
)(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        adc_valid,
    input  wire logic [1:0]  adc_channel,
    input  wire logic [7:0]  adc_sample,
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [15:0] cmd_wdata,
    output logic             rsp_valid,
    output logic [15:0]      rsp_data,
    output logic             rsp_refused,
    output logic             config_ready,
    output logic             output_on,
    output logic [3:0]       trim_steps
);

    // Sample words are packed for exactly eight bits; other widths are refused here
    if (ADC_BITS != 8)
    begin : adc_width_check
        $error("Only an 8-bit ADC is served");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [3:0] cfg_index(input logic [7:0] code);
        logic [3:0] idx;
        idx = IDX_NONE;
        for (int i = 0; i < CFG_N; i++)
            if (CFG_CODE[i] == code)
                idx = 4'(i);
        return idx;
    endfunction : cfg_index

    // Lock levels follow the usual three-step scheme; the lock itself stays writable
    function automatic logic write_locked(input logic [7:0] lock, input logic [3:0] idx);
        logic blocked;
        blocked = 1'b0;
        if (lock == LOCK_ALL)
            blocked = (idx != IDX_LOCK);
        else if (lock == LOCK_BUT_RUN)
            blocked = (idx != IDX_LOCK) && (idx != IDX_RUN);
        else if (lock == LOCK_BUT_ONOFF)
            blocked = (idx != IDX_LOCK) && (idx != IDX_RUN) && (idx != IDX_ONOFF);
        return blocked;
    endfunction : write_locked

    // Exponent of the sense ratio negated is the shift; ratios below 1/8 are clamped
    function automatic logic [7:0] vout_mode_of(input logic [15:0] ratio);
        logic [4:0] shift;
        shift = 5'(-ratio[15:11]);
        if (ratio[15] == 1'b0)
            shift = 5'h00;
        else if (shift > RATIO_MAX_SHIFT)
            shift = RATIO_MAX_SHIFT;
        return VOUT_MODE_BASE + {3'h0, shift};
    endfunction : vout_mode_of

    ////////////////////////////////////////////////////////////////////////////////
    // Load sequencer

    typedef enum logic {ST_LOAD, ST_RUN} load_state_e;

    load_state_e state_reg;
    logic [15:0] cfg_reg   [CFG_N];
    logic [15:0] store_reg [CFG_N];
    logic [15:0] iout_word_reg;
    logic [15:0] temp_word_reg;
    logic [15:0] vout_word_reg;

    logic [3:0]  req_idx;
    logic        is_store;
    logic        is_restore;
    logic        wr_ok;
    logic        restore_ok;
    logic        store_ok;
    logic        trim_bad;

    assign req_idx    = cfg_index(cmd_code);
    assign is_store   = (cmd_code == CODE_STORE_ALL);
    assign is_restore = (cmd_code == CODE_RESTORE_ALL);
    assign trim_bad   = ((req_idx == IDX_TRIM_UP) || (req_idx == IDX_TRIM_DN)) && (cmd_wdata > TRIM_MAX);
    assign wr_ok      = cmd_valid && cmd_write && (state_reg == ST_RUN) && (req_idx != IDX_NONE)
                        && !write_locked(cfg_reg[IDX_LOCK][7:0], req_idx) && !trim_bad;
    assign store_ok   = cmd_valid && cmd_write && (state_reg == ST_RUN) && is_store;
    assign restore_ok = cmd_valid && cmd_write && (state_reg == ST_RUN) && is_restore
                        && (cfg_reg[IDX_LOCK][7:0] == 8'h00);

    // Settings are not presented as valid until the store has been copied in
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            state_reg <= ST_LOAD;
        else
        begin
            case (state_reg)
                ST_LOAD: state_reg <= ST_RUN;
                ST_RUN:  state_reg <= restore_ok ? ST_LOAD : ST_RUN;
                default: state_reg <= ST_LOAD;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration and store

    // The store is modelled in flip-flops; a real part would keep it across power loss
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < CFG_N; i++)
                store_reg[i] <= CFG_DEFAULT[i];
        end
        else if (store_ok)
        begin
            for (int i = 0; i < CFG_N; i++)
                store_reg[i] <= cfg_reg[i];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < CFG_N; i++)
                cfg_reg[i] <= CFG_DEFAULT[i];
        end
        else if (state_reg == ST_LOAD)
        begin
            for (int i = 0; i < CFG_N; i++)
                cfg_reg[i] <= store_reg[i];
        end
        else if (wr_ok)
        begin
            // Limits keep the whole word, exponent included; scaling is up to the host
            cfg_reg[req_idx] <= CFG_IS_BYTE[req_idx] ? {8'h00, cmd_wdata[7:0]} : cmd_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Telemetry capture

    logic signed [8:0] temp_diff;
    assign temp_diff = $signed({1'b0, adc_sample}) - $signed({1'b0, TEMP_ZERO_CODE});

    // Whole words are built at sample time so a read can never mix two samples
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            iout_word_reg <= {IOUT_EXPONENT, 11'h000};
            temp_word_reg <= {TEMP_EXPONENT, 11'h000};
            vout_word_reg <= 16'h0000;
        end
        else if (adc_valid)
        begin
            case (adc_channel)
                CH_CURRENT: iout_word_reg <= {IOUT_EXPONENT, {3{adc_sample[7]}}, adc_sample};
                CH_TEMP:    temp_word_reg <= {TEMP_EXPONENT, {2{temp_diff[8]}}, temp_diff};
                CH_VOLTAGE: vout_word_reg <= {8'h00, adc_sample};
                default:    vout_word_reg <= vout_word_reg;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Command answers

    logic [15:0] rd_word;
    logic        rd_known;

    always_comb
    begin
        rd_word  = 16'h0000;
        rd_known = 1'b1;
        case (cmd_code)
            CODE_IOUT_READING:  rd_word = iout_word_reg;
            CODE_TEMP_READING:  rd_word = temp_word_reg;
            CODE_VOUT_READING:  rd_word = vout_word_reg;
            CODE_VOUT_EXPONENT: rd_word = {8'h00, vout_mode_of(cfg_reg[IDX_RATIO])};
            default:
            begin
                if (req_idx != IDX_NONE)
                    rd_word = cfg_reg[req_idx];
                else
                    rd_known = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rsp_valid   <= 1'b0;
            rsp_data    <= 16'h0000;
            rsp_refused <= 1'b0;
        end
        else
        begin
            rsp_valid   <= cmd_valid;
            rsp_data    <= (cmd_valid && !cmd_write) ? rd_word : 16'h0000;
            rsp_refused <= cmd_valid && (cmd_write ? !(wr_ok || store_ok || restore_ok) : !rd_known);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Settings handed to the regulation side

    logic [1:0] margin_sel;
    assign margin_sel = cfg_reg[IDX_RUN][RUN_MARGIN_HI:RUN_MARGIN_LO];

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            config_ready <= 1'b0;
            output_on    <= 1'b0;
            trim_steps   <= 4'h0;
        end
        else
        begin
            config_ready <= (state_reg == ST_RUN);
            output_on    <= (state_reg == ST_RUN) && cfg_reg[IDX_RUN][RUN_ON_BIT];
            if (margin_sel == MARGIN_HIGH)
                trim_steps <= cfg_reg[IDX_TRIM_UP][3:0];
            else if (margin_sel == MARGIN_LOW)
                trim_steps <= 4'(-cfg_reg[IDX_TRIM_DN][3:0]);
            else
                trim_steps <= 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    current_word_a: assert property (@(posedge clk) disable iff (!rst_n)
        adc_valid && adc_channel == CH_CURRENT |=> iout_word_reg[15:11] == 5'h1F
            && iout_word_reg[7:0] == $past(adc_sample))
        else $error("Current word not built from last sample");

    temp_word_a: assert property (@(posedge clk) disable iff (!rst_n)
        adc_valid && adc_channel == CH_TEMP && adc_sample == TEMP_ZERO_CODE |=> temp_word_reg == 16'h0000)
        else $error("Zero degree code not read as zero");

    vout_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
        cmd_valid && !cmd_write && cmd_code == CODE_VOUT_EXPONENT && cfg_reg[IDX_RATIO] == 16'hE801
            |=> rsp_data == 16'h001B)
        else $error("Ratio 1/8 not reported as 0x1B");

    power_load_a: assert property (@(posedge clk)
        !rst_n |=> !config_ready ##1 !config_ready)
        else $error("Ready before configuration load");

    lock_block_a: assert property (@(posedge clk) disable iff (!rst_n)
        cmd_valid && cmd_write && cfg_reg[IDX_LOCK][7:0] == LOCK_ALL && cmd_code == CODE_TURN_ON_SRC
            |=> rsp_refused && $stable(cfg_reg[IDX_ONOFF]))
        else $error("Locked write got through");

    store_copy_a: assert property (@(posedge clk) disable iff (!rst_n)
        store_ok |=> store_reg[IDX_RUN] == $past(cfg_reg[IDX_RUN]))
        else $error("Store did not copy configuration");

    trim_range_a: assert property (@(posedge clk) disable iff (!rst_n)
        cmd_valid && cmd_write && cmd_code == CODE_TRIM_UP && cmd_wdata > TRIM_MAX |=> rsp_refused)
        else $error("Out of range trim accepted");

    read_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
        cmd_valid && !cmd_write && cmd_code == CODE_IOUT_READING && !adc_valid
            |=> rsp_valid && rsp_data == iout_word_reg)
        else $error("Current read answered wrong word");

    ////////////////////////////////////////////////////////////////////////////////
    // Answer timing, restore and capture

    answer_next_a: assert property (@(posedge clk) disable iff (!rst_n)
        cmd_valid |=> rsp_valid)
        else $error("Command not answered in the next cycle");

    idle_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
        !cmd_valid |=> !rsp_valid && !rsp_refused && rsp_data == 16'h0000)
        else $error("Answer shown without a command");

    unknown_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        cmd_valid && !cmd_write && !rd_known
            |=> rsp_refused && rsp_data == 16'h0000)
        else $error("Unknown read not refused");

    mode_range_a: assert property (@(posedge clk) disable iff (!rst_n)
        cmd_valid && !cmd_write && cmd_code == CODE_VOUT_EXPONENT
            |=> rsp_data[15:2] == 14'h0006)
        else $error("Voltage exponent outside 0x18 to 0x1B");

    ratio_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_ok && req_idx == IDX_RATIO |=> cfg_reg[IDX_RATIO] == $past(cmd_wdata))
        else $error("Sense ratio write lost");

    byte_upper_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_ok && req_idx == IDX_RUN
            |=> cfg_reg[IDX_RUN] == {8'h00, $past(cmd_wdata[7:0])})
        else $error("Byte register kept upper bits");

    restore_ready_a: assert property (@(posedge clk) disable iff (!rst_n)
        restore_ok |-> ##2 !config_ready ##1 config_ready)
        else $error("Restore did not reload in one cycle");

    restore_load_a: assert property (@(posedge clk) disable iff (!rst_n)
        restore_ok |-> ##2 cfg_reg[IDX_RATIO] == store_reg[IDX_RATIO])
        else $error("Restore did not copy the store");

    restore_locked_a: assert property (@(posedge clk) disable iff (!rst_n)
        cmd_valid && cmd_write && cmd_code == CODE_RESTORE_ALL && cfg_reg[IDX_LOCK][7:0] != 8'h00
            |=> rsp_refused ##1 config_ready)
        else $error("Restore under write lock got through");

    output_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == ST_RUN |=> output_on == $past(cfg_reg[IDX_RUN][RUN_ON_BIT]))
        else $error("Output enable does not follow run control");

    trim_high_a: assert property (@(posedge clk) disable iff (!rst_n)
        margin_sel == MARGIN_HIGH |=> trim_steps == $past(cfg_reg[IDX_TRIM_UP][3:0]))
        else $error("Margin high trim not applied");

    temp_exponent_a: assert property (@(posedge clk) disable iff (!rst_n)
        adc_valid && adc_channel == CH_TEMP |=> temp_word_reg[15:11] == 5'h00)
        else $error("Temperature exponent not zero");

    vout_word_a: assert property (@(posedge clk) disable iff (!rst_n)
        adc_valid && adc_channel == CH_VOLTAGE
            |=> vout_word_reg == {8'h00, $past(adc_sample)})
        else $error("Voltage word not built from last sample");

    spare_channel_a: assert property (@(posedge clk) disable iff (!rst_n)
        adc_valid && adc_channel == 2'h3
            |=> $stable(iout_word_reg) && $stable(temp_word_reg) && $stable(vout_word_reg))
        else $error("Unused channel changed a reading");

endmodule : telemetry_cfg_regs

`default_nettype wire

// File: test/host_model.sv
// Host model that issues one command at a time on the command port.
// Assumes the register set answers on rsp_valid one cycle after each request.
`timescale 1ns/100ps
`default_nettype none

module host_model (
    input  wire logic        clk,
    output logic             cmd_valid,
    output logic             cmd_write,
    output logic [7:0]       cmd_code,
    output logic [15:0]      cmd_wdata,
    input  wire logic        rsp_valid,
    input  wire logic [15:0] rsp_data,
    input  wire logic        rsp_refused
);
    initial
    begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code  = 8'h00;
        cmd_wdata = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Idle data shows the inverse of the last word, so a stale value never passes as fresh
    task automatic xfer(
        input  logic        wr,
        input  logic [7:0]  code,
        input  logic [15:0] wdata,
        output logic [15:0] rdata,
        output logic        refused,
        output logic        answered
    );
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_code  <= code;
        cmd_wdata <= wdata;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_write <= ~wr;
        cmd_code  <= ~code;
        cmd_wdata <= ~wdata;
        #1;
        answered = rsp_valid;
        rdata    = rsp_data;
        refused  = rsp_refused;
    endtask : xfer
endmodule : host_model
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the telemetry and configuration register set.
// Assumes the host model drives the command port and this bench plays the ADC.
`timescale 1ns/100ps
`default_nettype none

module testbench;
    import telemetry_cfg_pkg::*;

    logic        clk         = 1'b0;
    logic        rst_n       = 1'b0;
    logic        adc_valid   = 1'b0;
    logic [1:0]  adc_channel = 2'h0;
    logic [7:0]  adc_sample  = 8'h00;
    logic        cmd_valid;
    logic        cmd_write;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_wdata;
    logic        rsp_valid;
    logic [15:0] rsp_data;
    logic        rsp_refused;
    logic        config_ready;
    logic        output_on;
    logic [3:0]  trim_steps;
    logic [15:0] rd;
    int          mismatches      = 0;
    int          samples_checked = 0;

    initial
    begin
        forever #5 clk = ~clk;
    end

    telemetry_cfg_regs dut (.clk(clk), .rst_n(rst_n), .adc_valid(adc_valid), .adc_channel(adc_channel),
        .adc_sample(adc_sample), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_refused(rsp_refused),
        .config_ready(config_ready), .output_on(output_on), .trim_steps(trim_steps));

    host_model host (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_refused(rsp_refused));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check_word

    task automatic check_bit(input string name, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask : check_bit

    task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d, input logic exp_ref);
        logic rf;
        logic an;
        host.xfer(w, c, d, rd, rf, an);
        check_bit("rsp_valid", 1'b1, an);
        check_bit("rsp_refused", exp_ref, rf);
    endtask : cmd

    task automatic rd_check(input string name, input logic [7:0] c, input logic [15:0] exp);
        cmd(1'b0, c, 16'h0000, 1'b0);
        check_word(name, exp, rd);
    endtask : rd_check

    task automatic adc(input logic [1:0] ch, input logic [7:0] val);
        @(posedge clk);
        adc_valid   <= 1'b1;
        adc_channel <= ch;
        adc_sample  <= val;
        @(posedge clk);
        adc_valid   <= 1'b0;
        adc_sample  <= ~val;
    endtask : adc

    // Bounded so a load that never finishes shows up as a mismatch, not a hang
    task automatic wait_ready();
        int n;
        n = 0;
        while (config_ready !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check_bit("config_ready", 1'b1, config_ready);
    endtask : wait_ready

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_defaults();
        for (int i = 0; i < CFG_N; i++)
            rd_check("default", CFG_CODE[i], CFG_DEFAULT[i]);
        check_bit("output_on", 1'b1, output_on);
        check_word("trim_steps", 16'h0000, {12'h000, trim_steps});
        $display("test_defaults done");
    endtask : test_defaults

    task automatic test_telemetry();
        adc(CH_CURRENT, 8'h14);
        rd_check("iout_pos", CODE_IOUT_READING, 16'hF814);
        adc(CH_CURRENT, 8'hF0);
        adc(2'h3, 8'h55);
        rd_check("iout_neg", CODE_IOUT_READING, 16'hFFF0);
        adc(CH_TEMP, 8'h55);
        rd_check("temp_pos", CODE_TEMP_READING, 16'h000A);
        adc(CH_TEMP, 8'h4A);
        rd_check("temp_neg", CODE_TEMP_READING, 16'h07FF);
        adc(CH_TEMP, 8'h4B);
        rd_check("temp_zero", CODE_TEMP_READING, 16'h0000);
        adc(CH_VOLTAGE, 8'hC8);
        rd_check("vout", CODE_VOUT_READING, 16'h00C8);
        $display("test_telemetry done");
    endtask : test_telemetry

    task automatic test_vout_mode();
        logic [15:0] ratio [4] = '{16'h0001, 16'hF801, 16'hF001, 16'hE801};
        for (int i = 0; i < 4; i++)
        begin
            cmd(1'b1, CODE_SENSE_RATIO, ratio[i], 1'b0);
            rd_check("vout_mode", CODE_VOUT_EXPONENT, 16'h0018 + 16'(i));
        end
        $display("test_vout_mode done");
    endtask : test_vout_mode

    task automatic test_limits();
        cmd(1'b1, CODE_OC_THRESH, 16'h0819, 1'b0);
        rd_check("oc_limit", CODE_OC_THRESH, 16'h0819);
        cmd(1'b1, CODE_OT_FAULT, 16'h1020, 1'b0);
        rd_check("ot_fault", CODE_OT_FAULT, 16'h1020);
        cmd(1'b1, CODE_IOUT_READING, 16'h0000, 1'b1);
        cmd(1'b0, 8'h99, 16'h0000, 1'b1);
        $display("test_limits done");
    endtask : test_limits

    task automatic test_margin();
        cmd(1'b1, CODE_TRIM_UP, 16'h0007, 1'b0);
        cmd(1'b1, CODE_TRIM_UP, 16'h0008, 1'b1);
        cmd(1'b1, CODE_RUN_CONTROL, 16'h00A0, 1'b0);
        repeat (2) @(posedge clk);
        #1;
        check_word("trim_hi", 16'h0007, {12'h000, trim_steps});
        cmd(1'b1, CODE_TRIM_DOWN, 16'h0003, 1'b0);
        cmd(1'b1, CODE_RUN_CONTROL, 16'h0010, 1'b0);
        repeat (2) @(posedge clk);
        #1;
        check_word("trim_lo", 16'h000D, {12'h000, trim_steps});
        check_bit("output_off", 1'b0, output_on);
        cmd(1'b1, CODE_RUN_CONTROL, 16'h0080, 1'b0);
        $display("test_margin done");
    endtask : test_margin

    task automatic test_lock();
        cmd(1'b1, CODE_WRITE_LOCK, {8'h00, LOCK_ALL}, 1'b0);
        cmd(1'b1, CODE_OC_THRESH, 16'h0815, 1'b1);
        rd_check("oc_locked", CODE_OC_THRESH, 16'h0819);
        cmd(1'b1, CODE_TURN_ON_SRC, 16'h0000, 1'b1);
        rd_check("onoff_locked", CODE_TURN_ON_SRC, 16'h0014);
        cmd(1'b1, CODE_RESTORE_ALL, 16'h0000, 1'b1);
        cmd(1'b1, CODE_WRITE_LOCK, {8'h00, LOCK_BUT_RUN}, 1'b0);
        cmd(1'b1, CODE_RUN_CONTROL, 16'h0080, 1'b0);
        cmd(1'b1, CODE_TURN_ON_SRC, 16'h0014, 1'b1);
        cmd(1'b1, CODE_WRITE_LOCK, {8'h00, LOCK_BUT_ONOFF}, 1'b0);
        cmd(1'b1, CODE_TURN_ON_SRC, 16'h0014, 1'b0);
        cmd(1'b1, CODE_RAMP_TIME, 16'h000E, 1'b1);
        cmd(1'b1, CODE_WRITE_LOCK, 16'h0000, 1'b0);
        $display("test_lock done");
    endtask : test_lock

    // Ready drops at the first edge after the restore is taken
    task automatic test_store();
        cmd(1'b1, CODE_RAMP_TIME, 16'hFF20, 1'b0);
        cmd(1'b1, CODE_STORE_ALL, 16'h0000, 1'b0);
        cmd(1'b1, CODE_RAMP_TIME, 16'h0030, 1'b0);
        cmd(1'b1, CODE_RESTORE_ALL, 16'h0000, 1'b0);
        @(posedge clk);
        #1;
        check_bit("ready_load", 1'b0, config_ready);
        wait_ready();
        rd_check("ramp_restored", CODE_RAMP_TIME, 16'h0020);
        $display("test_store done");
    endtask : test_store

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run

    // About 150 cycles of traffic; the limit leaves wide margin
    initial
    begin
        #50000;
        mismatches++;
        complete_run();
    end

    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        wait_ready();
        test_defaults();
        test_telemetry();
        test_vout_mode();
        test_limits();
        test_margin();
        test_lock();
        test_store();
        complete_run();
    end
endmodule : testbench
`default_nettype wire
